// ### rf_tag_frame_protocol_core.sv
/*
  Frame protocol core of a contactless vicinity tag: request reception with
  checksum check and addressing decision, tag state machine, response framing
  with appended checksum, and a small register port.
  Assumes a symbol decoder/encoder outside that gives bits with a link clock and a
  frame level, and a command executor that reads request bytes and supplies reply bytes.
*/
// Added by the designer: the plain strobed port and the register offsets.
`default_nettype none

// Function
// [R1] crc16 preset to all ones
// [R2] two crc bytes end every frame
// [R3] crc covers all bytes after start
// [R4] bad crc request dropped, no reply
// [R5] reader checks reply crc itself
// [R6] lsb first bits, lsbyte first fields
// [R7] reply only after accepted request
// [R8] request: flags, command, params, data, crc
// [R9] response: flags, params, data, crc
// [R10] frame bits multiple of eight
// [R11] optional fields present only when flagged
// [R12] four tag states only
// [R13] power-off until energy, then ready
// [R14] ready ignores select-only requests
// [R15] quiet ignores addressed inventory requests
// [R16] selected answers select, matching, general
// [R17] addressed request needs uid match; code skips the uid check when select flag is also set
// [R18] non-addressed request answered by all
// [R19] select-only answered only when selected
// [R20] field lost long enough gives power-off
// [R21] select flag is bit 5
// [R22] address flag is bit 6
// [R23] bit 3 switches flag meanings
// [R24] 64-bit read-only uid compared
// [R25] reflected poly, complemented crc sent
module rf_tag_frame_protocol_core #(
  parameter int unsigned LOSS_CYCLES = rf_tag_pkg::FIELD_LOSS_CYCLES,
  parameter logic [63:0] TAG_UID     = rf_tag_pkg::UID_DEFAULT
) (
  input  wire logic                 clk_sys,
  input  wire logic                 rst_n,
  input  wire logic                 energy_ok,
  input  wire logic                 field_present,
  input  wire logic                 link_clk,
  input  wire logic                 rx_frame,
  input  wire logic                 rx_data,
  output var  rf_tag_pkg::tx_line_t tx_line,
  output var  rf_tag_pkg::rx_out_t  rx_out,
  input  wire logic                 tx_valid,
  input  wire logic [7:0]           tx_byte,
  input  wire logic                 tx_last,
  output logic                      tx_ready,
  input  wire logic [7:0]           reg_addr,
  input  wire logic [31:0]          reg_wdata,
  input  wire logic                 reg_wr,
  input  wire logic                 reg_rd,
  output logic [31:0]               reg_rdata
);

  // ------------------------------------------------------------
  // functions
  // ------------------------------------------------------------
  function automatic logic [15:0] crc16_byte(input logic [15:0] crc, input logic [7:0] data);
    logic [15:0] c;
    c = crc ^ {8'h00, data};
    for (int i = 0; i < 8; i++) begin
      c = c[0] ? ((c >> 1) ^ rf_tag_pkg::CRC_POLY_REFL) : (c >> 1); // R25
    end
    return c;
  endfunction

  // ------------------------------------------------------------
  // synchronisers and edges
  // ------------------------------------------------------------
  logic [4:0] sync_a;
  logic [4:0] sync_b;
  logic       link_clk_d;
  logic       rx_frame_d;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sync_a     <= 5'h00;
      sync_b     <= 5'h00;
      link_clk_d <= 1'b0;
      rx_frame_d <= 1'b0;
    end else begin
      sync_a     <= {energy_ok, field_present, link_clk, rx_frame, rx_data};
      sync_b     <= sync_a;
      link_clk_d <= sync_b[2];
      rx_frame_d <= sync_b[1];
    end
  end

  wire logic energy_s  = sync_b[4];
  wire logic field_s   = sync_b[3];
  wire logic link_rise = sync_b[2] & ~link_clk_d;
  wire logic link_fall = ~sync_b[2] & link_clk_d;
  wire logic frame_s   = sync_b[1];
  wire logic frame_end = ~frame_s & rx_frame_d;
  wire logic data_s    = sync_b[0];

  // ------------------------------------------------------------
  // receive path
  // ------------------------------------------------------------
  logic [7:0]  rx_shreg;
  logic [3:0]  rx_bits;
  logic [7:0]  rx_count;
  logic [15:0] rx_crc;
  logic [7:0]  req_flags;
  logic        uid_ok;
  wire logic [7:0] next_shreg = {data_s, rx_shreg[7:1]}; // R6

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rx_shreg  <= 8'h00;
      rx_bits   <= 4'h0;
      rx_count  <= 8'h00;
      rx_crc    <= rf_tag_pkg::CRC_PRESET;
      req_flags <= 8'h00;
      uid_ok    <= 1'b1;
    end else if (!frame_s) begin
      rx_bits  <= 4'h0;
      if (!rx_frame_d) begin
        rx_count <= 8'h00;
        rx_crc   <= rf_tag_pkg::CRC_PRESET; // R1
        uid_ok   <= 1'b1;
      end
    end else if (link_rise) begin
      rx_shreg <= next_shreg;
      if (rx_bits == rf_tag_pkg::BITS_PER_BYTE - 4'h1) begin
        rx_bits <= 4'h0;
        rx_crc  <= crc16_byte(rx_crc, next_shreg); // R3
        if (rx_count != 8'hff) begin
          rx_count <= rx_count + 8'h01;
        end
        if (rx_count == rf_tag_pkg::IDX_FLAGS) begin
          req_flags <= next_shreg; // R8
        end
        if (rx_count >= rf_tag_pkg::IDX_UID_FIRST && rx_count <= rf_tag_pkg::IDX_UID_LAST &&
            next_shreg != TAG_UID[8 * (rx_count - rf_tag_pkg::IDX_UID_FIRST) +: 8]) begin
          uid_ok <= 1'b0; // R17 R24
        end
      end else begin
        rx_bits <= rx_bits + 4'h1;
      end
    end
  end

  // ------------------------------------------------------------
  // addressing decision
  // ------------------------------------------------------------
  rf_tag_pkg::tag_state_t tag_state;
  logic inv_req;
  logic sel_req;
  logic addr_req;
  logic conflict;
  logic answer;
  logic frame_good;

  assign inv_req  = req_flags[rf_tag_pkg::FLAG_INVENTORY]; // R23
  assign sel_req  = req_flags[rf_tag_pkg::FLAG_SELECT] & ~inv_req; // R21
  assign addr_req = req_flags[rf_tag_pkg::FLAG_ADDRESS] & ~inv_req; // R22
  assign conflict = sel_req & addr_req;

  always_comb begin
    answer = 1'b0;
    if (tag_state != rf_tag_pkg::TAG_POWER_OFF) begin
      if (inv_req) begin
        answer = !(tag_state == rf_tag_pkg::TAG_QUIET &&
                   req_flags[rf_tag_pkg::FLAG_ADDRESS]); // R15
      end else if (conflict) begin
        answer = 1'b1;
      end else if (sel_req) begin
        answer = (tag_state == rf_tag_pkg::TAG_SELECTED); // R14 R19 R16
      end else if (addr_req) begin
        answer = uid_ok; // R17 R16
      end else begin
        answer = 1'b1; // R18 R16
      end
    end
  end

  assign frame_good = (rx_crc == rf_tag_pkg::CRC_RESIDUE) && // R4 R2
                      (rx_bits == 4'h0) && // R10
                      (rx_count >= rf_tag_pkg::MIN_REQ_BYTES) &&
                      (!addr_req || rx_count >= rf_tag_pkg::MIN_ADDR_BYTES); // R11

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rx_out <= '0;
    end else begin
      rx_out.byte_valid    <= frame_s & link_rise &
                              (rx_bits == rf_tag_pkg::BITS_PER_BYTE - 4'h1);
      rx_out.byte_data     <= next_shreg;
      rx_out.accept        <= frame_end & frame_good & answer; // R4
      rx_out.drop          <= frame_end & ~(frame_good & answer); // R4
      rx_out.flag_conflict <= frame_end & frame_good & answer & conflict;
    end
  end

  // ------------------------------------------------------------
  // tag state machine
  // ------------------------------------------------------------
  logic [31:0] loss_count;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      loss_count <= 32'h0000_0000;
    end else if (field_s) begin
      loss_count <= 32'h0000_0000;
    end else if (loss_count < LOSS_CYCLES) begin
      loss_count <= loss_count + 32'h0000_0001;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      tag_state <= rf_tag_pkg::TAG_POWER_OFF; // R12
    end else if (!energy_s || loss_count >= LOSS_CYCLES) begin
      tag_state <= rf_tag_pkg::TAG_POWER_OFF; // R13 R20
    end else if (tag_state == rf_tag_pkg::TAG_POWER_OFF) begin
      tag_state <= rf_tag_pkg::TAG_READY; // R13
    end else if (reg_wr && reg_addr == rf_tag_pkg::REG_STATE &&
                 reg_wdata[1:0] != 2'h0) begin
      tag_state <= rf_tag_pkg::tag_state_t'(reg_wdata[1:0]);
    end
  end

  // ------------------------------------------------------------
  // transmit path
  // ------------------------------------------------------------
  rf_tag_pkg::tx_state_t tx_state;
  rf_tag_pkg::tx_phase_t tx_phase;
  logic        permit;
  logic [7:0]  tx_shreg;
  logic [3:0]  tx_bits;
  logic [15:0] tx_crc;
  logic        tx_is_last;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      permit <= 1'b0;
    end else if (tag_state == rf_tag_pkg::TAG_POWER_OFF || frame_s) begin
      permit <= 1'b0;
    end else if (rx_out.accept) begin
      permit <= 1'b1; // R7
    end else if (tx_state != rf_tag_pkg::TX_IDLE) begin
      permit <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      tx_state   <= rf_tag_pkg::TX_IDLE;
      tx_phase   <= rf_tag_pkg::PH_DATA;
      tx_shreg   <= 8'h00;
      tx_bits    <= 4'h0;
      tx_crc     <= rf_tag_pkg::CRC_PRESET;
      tx_is_last <= 1'b0;
      tx_ready   <= 1'b0;
      tx_line    <= '0;
    end else begin
      case (tx_state)
        rf_tag_pkg::TX_IDLE: begin
          tx_line <= '0;
          if (permit) begin
            tx_state <= rf_tag_pkg::TX_LOAD; // R7
            tx_phase <= rf_tag_pkg::PH_DATA;
            tx_crc   <= rf_tag_pkg::CRC_PRESET; // R1
            tx_ready <= 1'b1;
          end
        end
        rf_tag_pkg::TX_LOAD: begin
          if (frame_s || tag_state == rf_tag_pkg::TAG_POWER_OFF) begin
            tx_ready <= 1'b0;
            tx_state <= rf_tag_pkg::TX_IDLE; // R7
          end else if (tx_valid) begin
            tx_ready   <= 1'b0;
            tx_shreg   <= tx_byte; // R9
            tx_crc     <= crc16_byte(tx_crc, tx_byte); // R3
            tx_is_last <= tx_last;
            tx_bits    <= 4'h0;
            tx_state   <= rf_tag_pkg::TX_SHIFT;
          end
        end
        rf_tag_pkg::TX_SHIFT: begin
          if (link_fall) begin
            tx_line.frame     <= 1'b1;
            tx_line.bit_value <= tx_shreg[0]; // R6
            tx_shreg          <= tx_shreg >> 1;
            tx_bits           <= tx_bits + 4'h1;
            if (tx_bits == rf_tag_pkg::BITS_PER_BYTE - 4'h1) begin
              tx_bits <= 4'h0; // R10
              case (tx_phase)
                rf_tag_pkg::PH_DATA: begin
                  if (tx_is_last) begin
                    tx_phase <= rf_tag_pkg::PH_CRC_LO;
                    tx_shreg <= tx_crc[7:0] ^ rf_tag_pkg::CRC_FINAL_XOR[7:0]; // R25 R2
                  end else begin
                    tx_state <= rf_tag_pkg::TX_LOAD;
                    tx_ready <= 1'b1;
                  end
                end
                rf_tag_pkg::PH_CRC_LO: begin
                  tx_phase <= rf_tag_pkg::PH_CRC_HI;
                  tx_shreg <= tx_crc[15:8] ^ rf_tag_pkg::CRC_FINAL_XOR[15:8]; // R6
                end
                default: begin
                  tx_state <= rf_tag_pkg::TX_END;
                end
              endcase
            end
          end
        end
        rf_tag_pkg::TX_END: begin
          if (link_fall) begin
            tx_line  <= '0;
            tx_state <= rf_tag_pkg::TX_IDLE;
          end
        end
        default: begin
          tx_state <= rf_tag_pkg::TX_IDLE;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // register port
  // ------------------------------------------------------------
  logic [15:0] drop_count;
  logic [7:0]  last_flags;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      drop_count <= 16'h0000;
      last_flags <= 8'h00;
    end else begin
      if (rx_out.drop && drop_count != 16'hffff) begin
        drop_count <= drop_count + 16'h0001;
      end
      if (rx_out.accept) begin
        last_flags <= req_flags;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_rd) begin
      case (reg_addr)
        rf_tag_pkg::REG_STATE:      reg_rdata <= {30'h0, tag_state};
        rf_tag_pkg::REG_STATUS:     reg_rdata <= {28'h0, tx_state != rf_tag_pkg::TX_IDLE,
                                                  permit, field_s, energy_s};
        rf_tag_pkg::REG_DROP_COUNT: reg_rdata <= {16'h0, drop_count};
        rf_tag_pkg::REG_UID_LO:     reg_rdata <= TAG_UID[31:0]; // R24
        rf_tag_pkg::REG_UID_HI:     reg_rdata <= TAG_UID[63:32];
        rf_tag_pkg::REG_LAST_FLAGS: reg_rdata <= {24'h0, last_flags};
        default:                    reg_rdata <= 32'h0000_0000;
      endcase
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end

endmodule

`default_nettype wire

// ### rf_tag_frame_protocol_core_tb.sv
/*
  self-checking bench of the tag frame protocol core.
  assumes the reader model and the bound port checker.
*/
`default_nettype none
module rf_tag_frame_protocol_core_tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [63:0] UID = 64'h5a17_c3e0_0b9d_2468; // arbitrary value
  logic                 clk_sys = 1'b0;
  logic                 rst_n = 1'b0;
  logic                 energy_ok, field_present, link_clk, rx_frame, rx_data;
  logic                 tx_valid, tx_last, reg_wr, reg_rd;
  logic                 rd_q = 1'b0;
  logic [7:0]           bexp[$];
  logic [7:0]           tx_byte, reg_addr;
  logic [31:0]          reg_wdata, reg_rdata;
  logic                 tx_ready;
  rf_tag_pkg::tx_line_t tx_line;
  rf_tag_pkg::rx_out_t  rx_out;
  logic [2:0]           fexp[$];
  logic [31:0]          rexp[$];
  int                   mismatches, cmp_count;
  always #5 clk_sys = ~clk_sys;
  rf_tag_frame_protocol_core #(.LOSS_CYCLES(50), .TAG_UID(UID)) DUT (
    .clk_sys(clk_sys), .rst_n(rst_n), .energy_ok(energy_ok), .field_present(field_present),
    .link_clk(link_clk), .rx_frame(rx_frame), .rx_data(rx_data), .tx_line(tx_line),
    .rx_out(rx_out), .tx_valid(tx_valid), .tx_byte(tx_byte), .tx_last(tx_last),
    .tx_ready(tx_ready), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  rf_tag_reader_model reader (
    .link_clk(link_clk), .rx_frame(rx_frame), .rx_data(rx_data), .tx_line(tx_line));
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    cmp_count++;
    if (seen !== want) begin
      mismatches++;
      $display("BAD t=%0t seen %h want %h", $time, seen, want);
    end
  endtask
  always @(posedge clk_sys) begin
    if (rd_q) check(reg_rdata, rexp.pop_front());
    rd_q <= reg_rd;
    if (rx_out.byte_valid) check({24'h0, rx_out.byte_data}, {24'h0, bexp.pop_front()});
    if (rx_out.accept || rx_out.drop)
      check({29'h0, rx_out.accept, rx_out.drop, rx_out.flag_conflict}, {29'h0, fexp.pop_front()});
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] want);
    rexp.push_back(want);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic req(input logic [7:0] fl, input logic [63:0] uid, input logic bad,
                     input int tail, input logic [2:0] want);
    logic [7:0] b[$];
    logic [15:0] c;
    b = {fl, 8'($urandom)};
    if (fl[5] && !fl[2]) for (int i = 0; i < 8; i++) b.push_back(uid[8*i +: 8]);
    c = reader.crc16(b) ^ {15'h0, bad};
    bexp = {bexp, b, c[7:0], c[15:8]};
    fexp.push_back(want);
    reader.send(b, bad, tail);
    repeat (10) @(posedge clk_sys);
  endtask
  task automatic reply();
    logic [7:0]  d[$];
    logic [7:0]  got[$];
    logic [15:0] c;
    d = {8'($urandom), 8'($urandom)};
    fork
      reader.listen(got);
      begin
        foreach (d[i]) begin
          tx_byte <= d[i];
          tx_last <= (i == 1);
          tx_valid <= 1'b1;
          @(posedge clk_sys iff tx_ready);
        end
        tx_valid <= 1'b0;
        tx_last <= 1'b0;
      end
    join
    c = reader.crc16(d);
    d.push_back(c[7:0]);
    d.push_back(c[15:8]);
    check(got.size(), 4);
    foreach (d[i]) check(got[i], d[i]);
    @(posedge clk_sys);
  endtask
  task automatic complete_run();
    if (fexp.size() != 0 || bexp.size() != 0) mismatches++;
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    #800000;
    mismatches++;
    complete_run();
  end
  initial begin
    {energy_ok, field_present} = 2'b11;
    {tx_valid, tx_last, reg_wr, reg_rd} = 4'h0;
    {tx_byte, reg_addr, reg_wdata} = 48'h0;
    mismatches = 0;
    cmp_count = 0;
    void'($urandom(24803));
    repeat (8) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk_sys);
    rd(rf_tag_pkg::REG_STATE, 32'h1);
    rd(rf_tag_pkg::REG_STATUS, 32'h3);
    rd(rf_tag_pkg::REG_UID_HI, UID[63:32]);
    wr(rf_tag_pkg::REG_UID_LO, 32'h0);
    rd(rf_tag_pkg::REG_UID_LO, UID[31:0]);
    rd(8'h20, 32'h0);
    req(8'h02, 64'h0, 1'b0, 0, 3'b100);
    reply();
    req(8'h02, 64'h0, 1'b1, 0, 3'b010);
    req(8'h02, 64'h0, 1'b0, 3, 3'b010);
    req(8'h20, UID, 1'b0, 0, 3'b100);
    rd(rf_tag_pkg::REG_LAST_FLAGS, 32'h20);
    req(8'h20, ~UID, 1'b0, 0, 3'b010);
    req(8'h10, 64'h0, 1'b0, 0, 3'b010);
    rd(rf_tag_pkg::REG_DROP_COUNT, 32'h4);
    wr(rf_tag_pkg::REG_STATE, 32'h3);
    req(8'h10, 64'h0, 1'b0, 0, 3'b100);
    req(8'h30, UID, 1'b0, 0, 3'b101);
    req(8'h00, 64'h0, 1'b0, 0, 3'b100);
    wr(rf_tag_pkg::REG_STATE, 32'h2);
    req(8'h24, 64'h0, 1'b0, 0, 3'b010);
    req(8'h10, 64'h0, 1'b0, 0, 3'b010);
    req(8'h00, 64'h0, 1'b0, 0, 3'b100);
    wr(rf_tag_pkg::REG_STATE, 32'h0);
    rd(rf_tag_pkg::REG_STATE, 32'h2);
    energy_ok <= 1'b0;
    repeat (6) @(posedge clk_sys);
    rd(rf_tag_pkg::REG_STATE, 32'h0);
    energy_ok <= 1'b1;
    repeat (6) @(posedge clk_sys);
    rd(rf_tag_pkg::REG_STATE, 32'h1);
    field_present <= 1'b0;
    repeat (30) @(posedge clk_sys);
    field_present <= 1'b1;
    repeat (4) @(posedge clk_sys);
    rd(rf_tag_pkg::REG_STATE, 32'h1);
    field_present <= 1'b0;
    repeat (70) @(posedge clk_sys);
    rd(rf_tag_pkg::REG_STATE, 32'h0);
    complete_run();
  end
endmodule
`default_nettype wire

// ### rf_tag_monitor.sv
/*
  port checker of the tag frame protocol core.
  assumes binding onto rf_tag_frame_protocol_core.
*/
`default_nettype none
module rf_tag_monitor #(
  parameter logic [63:0] TAG_UID = rf_tag_pkg::UID_DEFAULT
) (
  input wire logic                 clk_sys,
  input wire logic                 rst_n,
  input wire logic                 rx_frame,
  input wire rf_tag_pkg::tx_line_t tx_line,
  input wire rf_tag_pkg::rx_out_t  rx_out,
  input wire logic                 tx_ready,
  input wire logic [7:0]           reg_addr,
  input wire logic                 reg_rd,
  input wire logic [31:0]          reg_rdata
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  logic granted;
  // reply permit seen from outside
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) granted <= 1'b0;
    else if (rx_out.accept) granted <= 1'b1;
    else if (rx_out.drop || $fell(tx_line.frame)) granted <= 1'b0;
  end
  a_verdict_excl: assert property (!(rx_out.accept && rx_out.drop))
    else $error("accept and drop together");
  a_accept_pulse: assert property (rx_out.accept |=> !rx_out.accept)
    else $error("accept longer than one cycle");
  a_verdict_time: assert property ($fell(rx_frame) |-> ##[2:6] (rx_out.accept || rx_out.drop))
    else $error("no verdict after frame end");
  a_permit_ready: assert property (rx_out.accept |-> ##[1:3] tx_ready)
    else $error("no byte request after accept");
  a_ready_granted: assert property (tx_ready |-> granted)
    else $error("byte request without accept");
  a_frame_granted: assert property ($rose(tx_line.frame) |-> granted)
    else $error("reply started without accept");
  a_drop_silent: assert property (rx_out.drop |=> !tx_ready [*8])
    else $error("reply after dropped request");
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside read slot");
  a_uid_read: assert property (reg_rd && reg_addr == rf_tag_pkg::REG_UID_LO |=> reg_rdata == TAG_UID[31:0])
    else $error("uid low word wrong");
  a_conflict_acc: assert property (rx_out.flag_conflict |-> rx_out.accept)
    else $error("conflict without accept");
endmodule
bind rf_tag_frame_protocol_core rf_tag_monitor #(.TAG_UID(TAG_UID)) mon (
  .clk_sys(clk_sys), .rst_n(rst_n), .rx_frame(rx_frame), .tx_line(tx_line),
  .rx_out(rx_out), .tx_ready(tx_ready), .reg_addr(reg_addr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata));
`default_nettype wire

// ### rf_tag_pkg.sv
/*
  Shared constants and types of the contactless tag frame protocol core:
  checksum constants, request flag positions, frame layout, register map,
  tag states and the carrier structs.
  Assumes a 100 MHz system clock.
*/
`default_nettype none

package rf_tag_pkg;

  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int unsigned CLK_MHZ            = 100;
  localparam int unsigned FIELD_LOSS_TIME_US = 1000;
  localparam int unsigned FIELD_LOSS_CYCLES  = FIELD_LOSS_TIME_US * CLK_MHZ;

  // ------------------------------------------------------------
  // checksum
  // ------------------------------------------------------------
  localparam logic [15:0] CRC_PRESET    = 16'hffff;
  localparam logic [15:0] CRC_POLY_REFL = 16'h8408;
  localparam logic [15:0] CRC_FINAL_XOR = 16'hffff;
  localparam logic [15:0] CRC_RESIDUE   = 16'hf0b8;

  // ------------------------------------------------------------
  // request flag byte and frame layout
  // ------------------------------------------------------------
  localparam int unsigned FLAG_INVENTORY  = 2;
  localparam int unsigned FLAG_SELECT     = 4;
  localparam int unsigned FLAG_ADDRESS    = 5;
  localparam logic [7:0]  IDX_FLAGS       = 8'h00;
  localparam logic [7:0]  IDX_UID_FIRST   = 8'h02;
  localparam logic [7:0]  IDX_UID_LAST    = 8'h09;
  localparam logic [7:0]  MIN_REQ_BYTES   = 8'h04;
  localparam logic [7:0]  MIN_ADDR_BYTES  = 8'h0c;
  localparam logic [3:0]  BITS_PER_BYTE   = 4'h8;
  localparam logic [63:0] UID_DEFAULT     = 64'h0123_4567_89ab_cdef; // arbitrary value

  // ------------------------------------------------------------
  // register map
  // ------------------------------------------------------------
  localparam logic [7:0] REG_STATE      = 8'h00;
  localparam logic [7:0] REG_STATUS     = 8'h04;
  localparam logic [7:0] REG_DROP_COUNT = 8'h08;
  localparam logic [7:0] REG_UID_LO     = 8'h0c;
  localparam logic [7:0] REG_UID_HI     = 8'h10;
  localparam logic [7:0] REG_LAST_FLAGS = 8'h14;

  // ------------------------------------------------------------
  // types
  // ------------------------------------------------------------
  typedef enum logic [1:0] {TAG_POWER_OFF, TAG_READY, TAG_QUIET, TAG_SELECTED} tag_state_t;
  typedef enum logic [1:0] {TX_IDLE, TX_LOAD, TX_SHIFT, TX_END} tx_state_t;
  typedef enum logic [1:0] {PH_DATA, PH_CRC_LO, PH_CRC_HI} tx_phase_t;

  typedef struct packed {
    logic       byte_valid;
    logic [7:0] byte_data;
    logic       accept;
    logic       drop;
    logic       flag_conflict;
  } rx_out_t;

  typedef struct packed {
    logic       frame;
    logic       bit_value;
  } tx_line_t;

endpackage

`default_nettype wire

// ### rf_tag_reader_model.sv
/*
  reader on the far side of the link: builds requests, clocks replies.
  assumes 160 ns link period, clock still outside exchanges.
*/
`default_nettype none
module rf_tag_reader_model (
  output logic                     link_clk,
  output logic                     rx_frame,
  output logic                     rx_data,
  input  wire rf_tag_pkg::tx_line_t tx_line
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    link_clk = 1'b0;
    rx_frame = 1'b0;
    rx_data  = 1'b0;
  end
  function automatic logic [15:0] crc16(input logic [7:0] b[$]);
    logic [15:0] c;
    c = 16'hffff;
    foreach (b[i]) begin
      c ^= {8'h00, b[i]};
      for (int k = 0; k < 8; k++) c = c[0] ? (c >> 1) ^ 16'h8408 : c >> 1;
    end
    return ~c;
  endfunction
  task automatic bit_out(input logic v);
    rx_data = v;
    #80 link_clk = 1'b1;
    #80 link_clk = 1'b0;
  endtask
  task automatic send(input logic [7:0] b[$], input logic bad, input int tail);
    logic [15:0] c;
    #7 c = crc16(b) ^ {15'h0, bad};
    b.push_back(c[7:0]);
    b.push_back(c[15:8]);
    rx_frame = 1'b1;
    foreach (b[i]) for (int k = 0; k < 8; k++) bit_out(b[i][k]);
    for (int k = 0; k < tail; k++) bit_out(1'b1);
    #80 rx_frame = 1'b0;
    rx_data = ~rx_data;
  endtask
  task automatic listen(output logic [7:0] r[$]);
    logic [7:0] v;
    int n;
    n = 0;
    r = {};
    #3;
    repeat (60) begin
      #80 link_clk = 1'b1;
      if (tx_line.frame) begin
        v[n % 8] = tx_line.bit_value;
        n++;
        if (n % 8 == 0) r.push_back(v);
      end
      #80 link_clk = 1'b0;
    end
  endtask
endmodule
`default_nettype wire
